// [src/trx_seq_pkg.sv]
// Package of timing constants and sequencer states for the transmit/receive switch
package trx_seq_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DEAD_TIME_MS = 3;
    localparam int unsigned TX_HOLD_MS = 6;
    localparam int unsigned ONE_SHOT_MS = 10;
    localparam int unsigned VOX_HOLD_MS = 200;
    localparam int unsigned NS_PER_MS = 1000000;
    // Least times round up to whole cycles
    localparam int unsigned DEAD_CYCLES = (DEAD_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYCLES = (TX_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned ONE_SHOT_CYCLES = (ONE_SHOT_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned VOX_HOLD_CYCLES = (VOX_HOLD_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 32;
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Sequencer states, Gray along rx -> tx -> rx dead time; the step back to rx changes two bits
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RX = 3'b000,
        ST_DEAD_TO_TX = 3'b001,
        ST_TX = 3'b011,
        ST_HOLD = 3'b010,
        ST_DEAD_TO_RX = 3'b110
    } seq_state_t;

    // Values after reset
    localparam logic RST_KEY = 1'b0;
    localparam logic [TIMER_W-1:0] RST_TIMER = 32'h00000000;

endpackage : trx_seq_pkg

// [src/input_sync.sv]
// Two-flop synchroniser bank for the asynchronous operator inputs
module input_sync #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Per-bit synchronisers
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_reg;
            logic stable_reg;
            // First flop is read only by the second to keep metastability contained
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= async_in[gi];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[gi] = stable_reg;
        end
    endgenerate

endmodule : input_sync

// [src/vox_detect.sv]
// Voice-operated detector: first-arrival latch, one-shot and hold delay
module vox_detect #(
    parameter int unsigned ONE_SHOT_CYCLES = trx_seq_pkg::ONE_SHOT_CYCLES,
    parameter int unsigned HOLD_CYCLES = trx_seq_pkg::VOX_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic mic_detect,
    input wire logic echo_detect,
    output logic voice_operated_switch
);

    // ------------------------------------------------------------------
    // First-arrival latch
    // ------------------------------------------------------------------
    logic latch_set_reg;
    logic latch_mic_reg;
    logic shot_reg;
    logic [31:0] shot_cnt_reg;
    logic [31:0] hold_cnt_reg;

    // Latch records which detector came first; a speaker echo wins the race
    // and then blocks voice keying until both detectors go quiet
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latch_set_reg <= 1'b0;
            latch_mic_reg <= 1'b0;
        end
        else if (!latch_set_reg && (mic_detect || echo_detect))
        begin
            latch_set_reg <= 1'b1;
            latch_mic_reg <= mic_detect && !echo_detect; // Tie goes to echo
        end
        else if (latch_set_reg && !mic_detect && !echo_detect && !shot_reg)
        begin
            latch_set_reg <= 1'b0;
            latch_mic_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // One-shot and hold delay
    // ------------------------------------------------------------------
    // One-shot retriggers while speech from the microphone persists
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shot_reg <= 1'b0;
            shot_cnt_reg <= 32'h00000000;
        end
        else if (latch_mic_reg && mic_detect)
        begin
            shot_reg <= 1'b1;
            shot_cnt_reg <= 32'(ONE_SHOT_CYCLES);
        end
        else if (shot_cnt_reg > 32'h00000001)
        begin
            shot_cnt_reg <= shot_cnt_reg - 32'h00000001;
        end
        else
        begin
            shot_reg <= 1'b0;
            shot_cnt_reg <= 32'h00000000;
        end
    end

    // Hold stage bridges pauses between words
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            voice_operated_switch <= 1'b0;
            hold_cnt_reg <= 32'h00000000;
        end
        else if (shot_reg)
        begin
            voice_operated_switch <= 1'b1;
            hold_cnt_reg <= 32'(HOLD_CYCLES);
        end
        else if (hold_cnt_reg > 32'h00000001)
        begin
            hold_cnt_reg <= hold_cnt_reg - 32'h00000001;
        end
        else
        begin
            voice_operated_switch <= 1'b0;
            hold_cnt_reg <= 32'h00000000;
        end
    end

    p_vox_follows_shot: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(shot_reg) |=> voice_operated_switch)
        else $error("voice switch did not follow one-shot");

endmodule : vox_detect

// [src/tx_rx_switch_sequencer.sv]
// Transmit/receive switch sequencer with dead time, key hold and gain gating
// Overview of operation
// - Drive level gate, keying line, tx supply, transmit indication, rx supply.
// - Hold both supplies off for about 3 ms between switching them.
// - Transmit indication high while transmitting, low while receiving.
// - Keep tx supply on about 6 ms after keying line release.
// - Signal and level gate fall before the tx supply drops.
// - Bias lines track tx supply; rx bias is inverse of tx bias.
// - Level control passes only while the keying line is active.
// - Rx supply and indication timing identical in every operating mode.
// - Voice path latches first detector, then one-shot and hold delay.
// - Receiver gain drive forced low whenever rx supply is removed.
module tx_rx_switch_sequencer #(
    parameter int unsigned DEAD_CYCLES = trx_seq_pkg::DEAD_CYCLES,
    parameter int unsigned HOLD_CYCLES = trx_seq_pkg::HOLD_CYCLES,
    parameter int unsigned ONE_SHOT_CYCLES = trx_seq_pkg::ONE_SHOT_CYCLES,
    parameter int unsigned VOX_HOLD_CYCLES = trx_seq_pkg::VOX_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cw_key,
    input wire logic push_to_talk,
    input wire logic mic_detect,
    input wire logic echo_detect,
    input wire logic vox_enable,
    input wire logic cw_mode,
    input wire logic level_in,
    input wire logic rx_gain_in,
    output logic level_control_gate,
    output logic cw_key_line,
    output logic tx_supply_enable,
    output logic transmit_indication,
    output logic rx_supply_enable,
    output logic tx_bias_line,
    output logic rx_bias_line,
    output logic level_out,
    output logic rx_gain_out
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [3:0] raw_in;
    logic [3:0] sync_in;
    logic key_s;
    logic ptt_s;
    logic mic_s;
    logic echo_s;
    logic voice_operated_switch;

    assign raw_in = {echo_detect, mic_detect, push_to_talk, cw_key};

    input_sync #(
        .WIDTH(4)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign key_s = sync_in[0];
    assign ptt_s = sync_in[1];
    assign mic_s = sync_in[2];
    assign echo_s = sync_in[3];

    vox_detect #(
        .ONE_SHOT_CYCLES(ONE_SHOT_CYCLES),
        .HOLD_CYCLES(VOX_HOLD_CYCLES)
    ) u_vox (
        .mclk(mclk),
        .rst_n(rst_n),
        .mic_detect(mic_s),
        .echo_detect(echo_s),
        .voice_operated_switch(voice_operated_switch)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    trx_seq_pkg::seq_state_t state_reg;
    logic [trx_seq_pkg::TIMER_W-1:0] timer_reg;
    logic tx_request;
    logic timer_done;

    // Key request applies the same path in every mode, so rx supply and
    // transmit indication timing never depend on mode
    assign tx_request = ptt_s || key_s || (vox_enable && voice_operated_switch);
    assign timer_done = (timer_reg == trx_seq_pkg::RST_TIMER);

    // State progression with one shared down-counter
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= trx_seq_pkg::ST_RX;
            timer_reg <= trx_seq_pkg::RST_TIMER;
        end
        else
        begin
            unique case (state_reg)
                trx_seq_pkg::ST_RX:
                begin
                    if (tx_request)
                    begin
                        state_reg <= trx_seq_pkg::ST_DEAD_TO_TX;
                        timer_reg <= 32'(DEAD_CYCLES - 1);
                    end
                end
                trx_seq_pkg::ST_DEAD_TO_TX:
                begin
                    if (timer_done)
                    begin
                        state_reg <= trx_seq_pkg::ST_TX;
                    end
                    else
                    begin
                        timer_reg <= timer_reg - 32'h00000001;
                    end
                end
                trx_seq_pkg::ST_TX:
                begin
                    if (!tx_request)
                    begin
                        state_reg <= trx_seq_pkg::ST_HOLD;
                        timer_reg <= 32'(HOLD_CYCLES - 1);
                    end
                end
                trx_seq_pkg::ST_HOLD:
                begin
                    if (tx_request)
                    begin
                        state_reg <= trx_seq_pkg::ST_TX;
                    end
                    else if (timer_done)
                    begin
                        state_reg <= trx_seq_pkg::ST_DEAD_TO_RX;
                        timer_reg <= 32'(DEAD_CYCLES - 1);
                    end
                    else
                    begin
                        timer_reg <= timer_reg - 32'h00000001;
                    end
                end
                trx_seq_pkg::ST_DEAD_TO_RX:
                begin
                    if (timer_done)
                    begin
                        state_reg <= trx_seq_pkg::ST_RX;
                    end
                    else
                    begin
                        timer_reg <= timer_reg - 32'h00000001;
                    end
                end
                default:
                begin
                    state_reg <= trx_seq_pkg::ST_RX;
                    timer_reg <= trx_seq_pkg::RST_TIMER;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    logic tx_supply_next;
    logic rx_supply_next;
    logic indication_next;
    logic key_next;

    // Indication flips at the start of each dead time so the synthesizer
    // settles while both supplies are off
    always_comb
    begin
        tx_supply_next = (state_reg == trx_seq_pkg::ST_TX) ||
            (state_reg == trx_seq_pkg::ST_HOLD);
        rx_supply_next = (state_reg == trx_seq_pkg::ST_RX) && !tx_request;
        indication_next = (state_reg != trx_seq_pkg::ST_RX) &&
            (state_reg != trx_seq_pkg::ST_DEAD_TO_RX);
        // Keying only inside full transmit; drops at hold entry, before supply
        key_next = (state_reg == trx_seq_pkg::ST_TX) &&
            (cw_mode ? key_s : tx_request);
    end

    // Registered drive of the five control lines and biases
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_supply_enable <= 1'b0;
            rx_supply_enable <= 1'b0;
            transmit_indication <= 1'b0;
            cw_key_line <= trx_seq_pkg::RST_KEY;
            level_control_gate <= 1'b0;
            tx_bias_line <= 1'b0;
            rx_bias_line <= 1'b1;
        end
        else
        begin
            tx_supply_enable <= tx_supply_next;
            rx_supply_enable <= rx_supply_next;
            transmit_indication <= indication_next;
            cw_key_line <= key_next;
            level_control_gate <= key_next;
            tx_bias_line <= tx_supply_next;
            rx_bias_line <= !tx_supply_next;
        end
    end

    // Analog-path gates as digital enables; a real design drives switches
    assign level_out = level_in && level_control_gate;
    assign rx_gain_out = rx_gain_in && rx_supply_enable;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    p_supply_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
        !(tx_supply_enable && rx_supply_enable))
        else $error("both supplies on");

    p_dead_after_rx: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(rx_supply_enable) |-> !tx_supply_enable [*3])
        else $error("tx supply came too soon after rx off");

    p_dead_after_tx: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(tx_supply_enable) |-> !rx_supply_enable [*3])
        else $error("rx supply came too soon after tx off");

    p_indication_tx: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_supply_enable |-> transmit_indication)
        else $error("indication low during transmit");

    p_indication_rx: assert property (@(posedge mclk) disable iff (!rst_n)
        rx_supply_enable |-> !transmit_indication)
        else $error("indication high during receive");

    p_bias_inverse: assert property (@(posedge mclk) disable iff (!rst_n)
        (rx_bias_line == !tx_bias_line) && (tx_bias_line == tx_supply_enable))
        else $error("bias lines out of step");

    p_gate_before_drop: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(tx_supply_enable) |-> !$past(level_control_gate))
        else $error("level gate still on at supply drop");

    p_hold_time: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(cw_key_line) && !tx_request && cw_mode |=> tx_supply_enable [*2])
        else $error("tx supply dropped without hold");

    p_level_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        !cw_key_line |-> !level_out)
        else $error("level passed without keying");

    p_gain_forced: assert property (@(posedge mclk) disable iff (!rst_n)
        !rx_supply_enable |-> !rx_gain_out)
        else $error("rx gain active without rx supply");

endmodule : tx_rx_switch_sequencer

// [testbench/supply_switch_model.sv]
// Far-side model of the supply switches and synthesizer driven by the sequencer
module supply_switch_model #(
    parameter int unsigned RAIL_DELAY = 2
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tx_en,
    input wire logic rx_en,
    input wire logic tx_mark,
    output logic rail_clash,
    output logic synth_glitch
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] tx_cnt_reg;
    logic [7:0] rx_cnt_reg;
    logic mark_reg;

    // Rails ramp up and decay over RAIL_DELAY cycles, so a short pause lets them overlap
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_cnt_reg <= 8'h00;
            rx_cnt_reg <= 8'h00;
        end
        else
        begin
            if (tx_en && tx_cnt_reg != RAIL_DELAY[7:0])
                tx_cnt_reg <= tx_cnt_reg + 8'h01;
            else if (!tx_en && tx_cnt_reg != 8'h00)
                tx_cnt_reg <= tx_cnt_reg - 8'h01;
            if (rx_en && rx_cnt_reg != RAIL_DELAY[7:0])
                rx_cnt_reg <= rx_cnt_reg + 8'h01;
            else if (!rx_en && rx_cnt_reg != 8'h00)
                rx_cnt_reg <= rx_cnt_reg - 8'h01;
        end
    end

    // Sticky flags: both rails alive, or synthesizer changeover outside the pause
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail_clash <= 1'b0;
            synth_glitch <= 1'b0;
            mark_reg <= 1'b0;
        end
        else
        begin
            mark_reg <= tx_mark;
            if (tx_cnt_reg != 8'h00 && rx_cnt_reg != 8'h00)
                rail_clash <= 1'b1;
            if (tx_mark != mark_reg && (tx_en || rx_en))
                synth_glitch <= 1'b1;
        end
    end
endmodule : supply_switch_model

// [testbench/tx_rx_switch_sequencer_tb.sv]
// Self-checking bench for the transmit/receive switch sequencer
module tx_rx_switch_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Shortened counts and signals
    // ------------------------------------------------------------------
    localparam int DEAD = 5;
    localparam int HOLD = 8;
    localparam int SHOT = 4;
    localparam int VHOLD = 20;
    localparam int RX = 0;
    localparam int TX = 1;
    localparam int KEY = 2;
    logic mclk, rst_n, cw_key, push_to_talk, mic_detect, echo_detect, vox_enable, cw_mode;
    logic level_in, rx_gain_in, level_control_gate, cw_key_line, tx_supply_enable;
    logic transmit_indication, rx_supply_enable, tx_bias_line, rx_bias_line, level_out;
    logic rx_gain_out, rail_clash, synth_glitch;
    int failures, n_checks, dead_ref, n, quiet_hits;
    bit quiet_watch;

    tx_rx_switch_sequencer #(.DEAD_CYCLES(DEAD), .HOLD_CYCLES(HOLD), .ONE_SHOT_CYCLES(SHOT),
        .VOX_HOLD_CYCLES(VHOLD)) i_tx_rx_switch_sequencer (.mclk(mclk), .rst_n(rst_n),
        .cw_key(cw_key), .push_to_talk(push_to_talk), .mic_detect(mic_detect),
        .echo_detect(echo_detect), .vox_enable(vox_enable), .cw_mode(cw_mode),
        .level_in(level_in), .rx_gain_in(rx_gain_in), .level_control_gate(level_control_gate),
        .cw_key_line(cw_key_line), .tx_supply_enable(tx_supply_enable),
        .transmit_indication(transmit_indication), .rx_supply_enable(rx_supply_enable),
        .tx_bias_line(tx_bias_line), .rx_bias_line(rx_bias_line), .level_out(level_out),
        .rx_gain_out(rx_gain_out));

    // Slow rails, so a dead time shorter than the decay shows up as a clash
    supply_switch_model #(.RAIL_DELAY(3)) i_supply_switch_model (.mclk(mclk), .rst_n(rst_n),
        .tx_en(tx_supply_enable), .rx_en(rx_supply_enable), .tx_mark(transmit_indication),
        .rail_clash(rail_clash), .synth_glitch(synth_glitch));

    // ------------------------------------------------------------------
    // Clock, random level inputs and continuous output checks
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        #1;
        level_in = 1'($urandom);
        rx_gain_in = 1'($urandom);
    end

    // Sampled at the falling edge, where every registered output has settled
    always @(negedge mclk)
    begin
        if (rst_n === 1'b1)
        begin
            chk(tx_bias_line === tx_supply_enable && rx_bias_line === !tx_supply_enable, "bias");
            chk(level_control_gate === cw_key_line, "gate differs from key line");
            chk(level_out === (level_in & level_control_gate), "level path");
            chk(rx_gain_out === (rx_gain_in & rx_supply_enable), "rx gain drive");
            chk(!(tx_supply_enable && rx_supply_enable) === 1'b1, "supply overlap");
            chk(!(tx_supply_enable && !transmit_indication) === 1'b1, "indication low in tx");
            chk(!(rx_supply_enable && transmit_indication) === 1'b1, "indication high in rx");
            chk((!cw_key_line || tx_supply_enable) === 1'b1, "keyed without supply");
            if (quiet_watch && rx_supply_enable !== 1'b1)
                quiet_hits++;
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok)
        begin
            failures++;
            $display("MISMATCH at %0t ns: %s", $time, msg);
        end
    endtask : chk

    task automatic end_sim();
        chk(rail_clash === 1'b0 && synth_glitch === 1'b0, "far side flagged a clash");
        $display("Checks: %0d, mismatches: %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // Counts falling edges until the chosen output reaches a value; bounded
    task automatic wait_bit(input int idx, input logic val, input int lim, output int cnt);
        logic [2:0] obs;
        cnt = 0;
        do
        begin
            @(negedge mclk);
            cnt++;
            obs = {cw_key_line, tx_supply_enable, rx_supply_enable};
            if (cnt > lim)
            begin
                chk(1'b0, "wait ran out");
                end_sim();
            end
        end
        while (obs[idx] !== val);
    endtask : wait_bit

    task automatic set_req(input int kind, input logic v);
        @(posedge mclk);
        #1;
        if (kind == 0)
            cw_key = v;
        else
            push_to_talk = v;
    endtask : set_req

    // One full receive-transmit-receive pass, optionally re-keying inside the hold
    task automatic do_tx(input int kind, input logic mode, input bit rekey);
        int cnt;
        @(posedge mclk);
        #1;
        cw_mode = mode;
        // In CW mode the keying line follows only the key, so talk requests use the key
        if (mode)
            kind = 0;
        set_req(kind, 1'b1);
        wait_bit(RX, 1'b0, 6, cnt);
        wait_bit(TX, 1'b1, DEAD + 10, cnt);
        chk(cnt >= DEAD && cnt <= DEAD + 2, "dead time before tx");
        if (dead_ref < 0)
            dead_ref = cnt;
        chk(cnt == dead_ref, "dead time differs between modes");
        wait_bit(KEY, 1'b1, 3, cnt);
        repeat (2 + $urandom % 12) @(posedge mclk);
        set_req(kind, 1'b0);
        wait_bit(KEY, 1'b0, 5, cnt);
        if (rekey)
        begin
            set_req(kind, 1'b1);
            wait_bit(KEY, 1'b1, 8, cnt);
            chk(tx_supply_enable === 1'b1 && rx_supply_enable === 1'b0, "rekey in hold");
            set_req(kind, 1'b0);
            wait_bit(KEY, 1'b0, 5, cnt);
        end
        wait_bit(TX, 1'b0, HOLD + 10, cnt);
        chk(cnt >= HOLD - 1 && cnt <= HOLD + 2, "tx hold after key release");
        chk(transmit_indication === 1'b0, "indication after tx off");
        wait_bit(RX, 1'b1, DEAD + 10, cnt);
        chk(cnt >= DEAD && cnt <= DEAD + 2, "dead time before rx");
    endtask : do_tx

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, cw_key, push_to_talk, mic_detect, echo_detect, vox_enable} = 6'h00;
        {cw_mode, level_in, rx_gain_in, quiet_watch} = 4'h0;
        failures = 0;
        n_checks = 0;
        dead_ref = -1;
        quiet_hits = 0;
        void'($urandom(30));
        repeat (3) @(posedge mclk);
        #1;
        chk({tx_supply_enable, rx_supply_enable, rx_bias_line} === 3'h1, "outputs in reset");
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        wait_bit(RX, 1'b1, 4, n);
        // Key requests in both keying modes, talk requests with CW mode off, the last with a re-key
        for (int i = 0; i < 4; i++)
            do_tx(i % 2, 1'(i / 2), i == 3);
        repeat (4) do_tx($urandom % 2, 1'($urandom), 1'($urandom));
        // Voice keying: microphone first
        @(posedge mclk);
        #1;
        {vox_enable, cw_mode, mic_detect} = 3'h5;
        wait_bit(RX, 1'b0, 12, n);
        mic_detect = 1'b0;
        wait_bit(TX, 1'b1, DEAD + 10, n);
        wait_bit(TX, 1'b0, SHOT + VHOLD + HOLD + 20, n);
        wait_bit(RX, 1'b1, DEAD + 10, n);
        // Echo first must block voice keying
        @(posedge mclk);
        #1;
        echo_detect = 1'b1;
        quiet_watch = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        mic_detect = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        {mic_detect, echo_detect} = 2'h0;
        repeat (SHOT + VHOLD + 10) @(posedge mclk);
        quiet_watch = 1'b0;
        chk(quiet_hits == 0, "echo first still keyed");
        // Reset in the middle of a transmission
        #1;
        vox_enable = 1'b0;
        set_req(0, 1'b1);
        wait_bit(TX, 1'b1, DEAD + 12, n);
        rst_n = 1'b0;
        #2;
        chk({tx_supply_enable, rx_supply_enable, rx_bias_line} === 3'h1, "reset in tx");
        cw_key = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        wait_bit(RX, 1'b1, 4, n);
        chk(tx_supply_enable === 1'b0, "tx supply after reset");
        end_sim();
    end
endmodule : tx_rx_switch_sequencer_tb
